// [bench/ps2_channel_receiver_tb.sv]
// Self-checking bench for the PS/2 receive channel.
`default_nettype none
`include "ps2_rx_regs.vh"

module ps2_channel_receiver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       I_CLOCK = 1'b0;
  logic       I_RESET_N = 1'b0;
  logic [3:0] I_ADDR = 4'h0;
  logic [7:0] I_WDATA = 8'h00;
  logic       I_WR = 1'b0;
  logic       I_RD = 1'b0;
  logic [7:0] O_RDATA;
  logic       O_INT, O_LINK_CLK, O_LINK_CLK_OE_N, O_LINK_DATA, O_LINK_DATA_OE_N;
  logic       clk_low;
  logic       dat_low;
  wire        link_clk;
  wire        link_dat;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  logic [7:0] rx_bytes [4] = '{8'ha5, 8'h00, 8'hff, 8'h3c};
  // Open-drain wires with pull-ups: any party pulling low wins.
  assign link_clk = (O_LINK_CLK_OE_N | O_LINK_CLK) & ~clk_low;
  assign link_dat = (O_LINK_DATA_OE_N | O_LINK_DATA) & ~dat_low;
  always #50 I_CLOCK = ~I_CLOCK;
  ps2_channel_receiver dut_u (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_INT(O_INT),
    .I_LINK_CLK(link_clk), .O_LINK_CLK(O_LINK_CLK), .O_LINK_CLK_OE_N(O_LINK_CLK_OE_N),
    .I_LINK_DATA(link_dat), .O_LINK_DATA(O_LINK_DATA), .O_LINK_DATA_OE_N(O_LINK_DATA_OE_N));
  ps2_kbd_model kbd_u (.o_clk_low(clk_low), .o_dat_low(dat_low));
  // Bus helpers: strobes are launched just after an edge and dropped after one cycle.
  task automatic tick;
    @(posedge I_CLOCK);
    #1;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    tick;
    I_WR <= 1'b0;
    tick;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    I_ADDR <= a;
    I_RD <= 1'b1;
    tick;
    I_RD <= 1'b0;
    chk(O_RDATA, e);
    tick;
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge I_CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out;
    end
  end
  // Main sequence: reset values, clean frames, a parity fault, a gap abort, then forced lines.
  initial begin
    repeat (12) @(posedge I_CLOCK);
    I_RESET_N <= 1'b1;
    repeat (3) tick;
    rdchk(`RX_ADDR_CTRL, {4'h0, `RX_CTRL_RESET});
    rdchk(`RX_ADDR_STATUS, 8'h00);
    rdchk(`RX_ADDR_INTSRC, 8'h00);
    rdchk(`RX_ADDR_DATA, 8'h00);
    $display("test reset done");
    foreach (rx_bytes[i]) begin
      kbd_u.send(rx_bytes[i], 1'b0, 11);
      tick;
      repeat (12) if (O_INT !== 1'b1) tick;
      chk({7'h0, O_INT}, 8'h01);
      chk({7'h0, link_clk}, 8'h00);
      rdchk(`RX_ADDR_STATUS, 8'h05);
      rdchk(`RX_ADDR_DATA, rx_bytes[i]);
      rdchk(`RX_ADDR_STATUS, 8'h00);
      chk({7'h0, link_clk}, 8'h01);
      chk({7'h0, O_INT}, 8'h01);
      rdchk(`RX_ADDR_INTSRC, 8'h01);
      chk({7'h0, O_INT}, 8'h00);
    end
    $display("test frames done");
    kbd_u.send(8'h5a, 1'b1, 11);
    repeat (20) tick;
    rdchk(`RX_ADDR_STATUS, 8'h02);
    rdchk(`RX_ADDR_STATUS, 8'h00);
    chk({6'h0, link_clk, O_INT}, 8'h02);
    $display("test parity fault done");
    kbd_u.send(8'h81, 1'b0, 4);
    repeat (3100) tick;
    kbd_u.send(8'h96, 1'b0, 11);
    repeat (20) tick;
    rdchk(`RX_ADDR_STATUS, 8'h05);
    rdchk(`RX_ADDR_DATA, 8'h96);
    rdchk(`RX_ADDR_INTSRC, 8'h01);
    $display("test gap abort done");
    wr(`RX_ADDR_CTRL, 8'h00);
    chk({4'h0, O_LINK_CLK_OE_N, O_LINK_DATA_OE_N, link_clk, link_dat}, 8'h00);
    wr(`RX_ADDR_CTRL, 8'h0c);
    chk({4'h0, O_LINK_CLK_OE_N, O_LINK_DATA_OE_N, link_clk, link_dat}, 8'h03);
    wr(4'h7, 8'h01);
    rdchk(`RX_ADDR_CTRL, 8'h0c);
    wr(`RX_ADDR_CTRL, 8'h03);
    chk({4'h0, O_LINK_CLK_OE_N, O_LINK_DATA_OE_N, link_clk, link_dat}, 8'h05);
    wr(`RX_ADDR_CTRL, 8'h01);
    chk({4'h0, O_LINK_CLK_OE_N, O_LINK_DATA_OE_N, link_clk, link_dat}, 8'h0f);
    $display("test line control done");
    close_out;
  end
endmodule
`default_nettype wire

// [bench/ps2_kbd_model.sv]
// Behavioural PS/2 peripheral that clocks frames into the channel.
`default_nettype none

module ps2_kbd_model (
  output var logic o_clk_low,
  output var logic o_dat_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both open-drain lines start released; the clock idles high between frames.
  initial begin
    o_clk_low = 1'b0;
    o_dat_low = 1'b0;
  end
  // Sends the first n bits of one frame; a set bad flag inverts the parity bit.
  task automatic send(input logic [7:0] b, input logic bad, input int n);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    #13;
    for (int i = 0; i < n; i++) begin
      o_dat_low = ~f[i];
      #400 o_clk_low = 1'b1;
      #400 o_clk_low = 1'b0;
    end
    o_dat_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/ps2_rx_props.sv]
// Concurrent checks on the ports of the PS/2 receive channel.
`default_nettype none
`include "ps2_rx_regs.vh"

module ps2_rx_props (
  input wire logic       I_CLOCK,
  input wire logic       I_RESET_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic       O_INT,
  input wire logic       I_LINK_CLK,
  input wire logic       O_LINK_CLK,
  input wire logic       O_LINK_CLK_OE_N,
  input wire logic       I_LINK_DATA,
  input wire logic       O_LINK_DATA,
  input wire logic       O_LINK_DATA_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_p_q;
  logic       ctrl_wr;
  logic       rx_mode;
  // Shadow of the control register; a mode counts once pins had time to follow.
  assign ctrl_wr = I_WR && I_ADDR == `RX_ADDR_CTRL;
  assign rx_mode = ctrl_q[1:0] == 2'b01 && ctrl_p_q == ctrl_q;
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      ctrl_q <= `RX_CTRL_RESET;
      ctrl_p_q <= `RX_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_wr ? I_WDATA[3:0] : ctrl_q;
      ctrl_p_q <= ctrl_q;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  property p_release_rx; ctrl_wr && I_WDATA[1:0] == 2'b01 |=> O_LINK_DATA_OE_N; endproperty
  a_release_rx: assert property (p_release_rx) else $error("data line not released");
  property p_rx_float; rx_mode |-> O_LINK_DATA_OE_N; endproperty
  a_rx_float: assert property (p_rx_float) else $error("data line driven in receive");
  property p_dis_wr; ctrl_wr && !I_WDATA[0] |=> !O_LINK_CLK_OE_N && !O_LINK_DATA_OE_N;
  endproperty
  a_dis_wr: assert property (p_dis_wr) else $error("lines not driven when disabled");
  property p_dis_hold; !ctrl_q[0] && ctrl_p_q == ctrl_q |-> !O_LINK_CLK_OE_N
    && !O_LINK_DATA_OE_N && O_LINK_CLK == ctrl_q[2] && O_LINK_DATA == ctrl_q[3]; endproperty
  a_dis_hold: assert property (p_dis_hold) else $error("override values not driven");
  property p_rd_release; I_RD && I_ADDR == `RX_ADDR_DATA && rx_mode |=> O_LINK_CLK_OE_N;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("clock kept after read");
  property p_inhibit_low; rx_mode && !O_LINK_CLK_OE_N |-> !O_LINK_CLK; endproperty
  a_inhibit_low: assert property (p_inhibit_low) else $error("inhibit not low");
  property p_int_time; $fell(O_LINK_CLK_OE_N) && rx_mode |-> ##[0:16] O_INT; endproperty
  a_int_time: assert property (p_int_time) else $error("interrupt late after byte");
  property p_int_inhibit; $rose(O_INT) |-> !O_LINK_CLK_OE_N; endproperty
  a_int_inhibit: assert property (p_int_inhibit) else $error("interrupt without byte");
  property p_int_clear; $fell(O_INT) |-> $past(I_RD && I_ADDR == `RX_ADDR_INTSRC);
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt dropped unread");
  c_byte: cover property ($rose(O_INT));
  c_release: cover property ($rose(O_LINK_CLK_OE_N) && rx_mode);
  c_disabled: cover property (!ctrl_q[0] && ctrl_p_q == ctrl_q);
endmodule

bind ps2_channel_receiver ps2_rx_props props_u (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_INT(O_INT), .I_LINK_CLK(I_LINK_CLK), .O_LINK_CLK(O_LINK_CLK),
  .O_LINK_CLK_OE_N(O_LINK_CLK_OE_N), .I_LINK_DATA(I_LINK_DATA),
  .O_LINK_DATA(O_LINK_DATA), .O_LINK_DATA_OE_N(O_LINK_DATA_OE_N));
`default_nettype wire

// [design/ps2_channel_receiver.v]
// Receive path of one PS/2 channel with register port and line drivers.
//
// Added by the designer: the register addresses and the plain strobed port.
`include "ps2_rx_regs.vh"
`default_nettype none

module ps2_channel_receiver (
  input  wire       I_CLOCK,
  input  wire       I_RESET_N,
  input  wire [3:0] I_ADDR,
  input  wire [7:0] I_WDATA,
  input  wire       I_WR,
  input  wire       I_RD,
  output reg  [7:0] O_RDATA,
  output reg        O_INT,
  input  wire       I_LINK_CLK,
  output reg        O_LINK_CLK,
  output reg        O_LINK_CLK_OE_N,
  input  wire       I_LINK_DATA,
  output reg        O_LINK_DATA,
  output reg        O_LINK_DATA_OE_N
);

  // -----------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------

  // Address decode shared by read and write paths.
  function hit;
    input [3:0] addr;
    input [3:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  reg  [3:0]  ctrl_q;
  reg  [3:0]  ctrl_d;
  reg         clk_meta_q;
  reg         clk_sync_q;
  reg         clk_prev_q;
  reg         dat_meta_q;
  reg         dat_sync_q;
  reg  [3:0]  bit_cnt_q;
  reg  [9:0]  shift_q;
  reg  [11:0] gap_cnt_q;
  reg         inhibit_q;
  reg         inhibit_d;
  reg         push_q;
  reg  [7:0]  push_data_q;
  reg         frm_err_q;
  reg         int_pend_q;
  reg         int_pend_d;
  reg         ready_prev_q;
  reg         clk_out_d;
  reg         clk_oe_n_d;
  reg         dat_out_d;
  reg         dat_oe_n_d;
  reg  [7:0]  rdata_d;
  wire        receiving;
  wire        fall;
  wire        last_bit;
  wire        frame_ok;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire        fifo_full;
  wire        rd_data;
  wire        rd_status;
  wire        rd_intsrc;
  wire        wr_ctrl;
  wire        pop;

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------

  // Strobes qualified by the decoded address.
  assign wr_ctrl   = I_WR && hit(I_ADDR, `RX_ADDR_CTRL);
  assign rd_status = I_RD && hit(I_ADDR, `RX_ADDR_STATUS);
  assign rd_data   = I_RD && hit(I_ADDR, `RX_ADDR_DATA);
  assign rd_intsrc = I_RD && hit(I_ADDR, `RX_ADDR_INTSRC);

  // A read of the receive register takes the head byte out of the FIFO.
  assign pop = rd_data && fifo_out_valid;

  // -----------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------

  // Next control value, used at once by the line drivers below.
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = I_WDATA[3:0];
    end
  end

  // The control register holds enable, direction and the two overrides.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      ctrl_q <= `RX_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Receive mode means enabled with the direction set to receive.
  assign receiving = ctrl_q[`RX_CTRL_ENABLE] && !ctrl_q[`RX_CTRL_DIR];

  // -----------------------------------------------------------------
  // Link synchronisers
  // -----------------------------------------------------------------

  // Both link lines pass two flip-flops before any logic looks at them.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      clk_meta_q <= 1'b1;
      clk_sync_q <= 1'b1;
      clk_prev_q <= 1'b1;
      dat_meta_q <= 1'b1;
      dat_sync_q <= 1'b1;
    end else begin
      clk_meta_q <= I_LINK_CLK;
      clk_sync_q <= clk_meta_q;
      clk_prev_q <= clk_sync_q;
      dat_meta_q <= I_LINK_DATA;
      dat_sync_q <= dat_meta_q;
    end
  end

  // A falling link clock edge seen on the synchronised line.
  assign fall = clk_prev_q && !clk_sync_q && receiving && !inhibit_q;

  // -----------------------------------------------------------------
  // Frame receiver
  // -----------------------------------------------------------------

  // The eleventh falling edge ends the frame.
  assign last_bit = (bit_cnt_q == `RX_FRAME_BITS);

  // Start low, odd parity over data and parity, stop high.
  assign frame_ok = !shift_q[0] && (^shift_q[9:1]) && dat_sync_q;

  // Bit counter and shift register; a long quiet gap aborts a partial frame,
  // since no valid peripheral clock phase can last that long.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 10'h000;
      gap_cnt_q <= 12'h000;
    end else if (!receiving) begin
      bit_cnt_q <= 4'h0;
      gap_cnt_q <= 12'h000;
    end else if (fall) begin
      gap_cnt_q <= 12'h000;
      if (last_bit) begin
        bit_cnt_q <= 4'h0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= {dat_sync_q, shift_q[9:1]};
      end
    end else if (bit_cnt_q != 4'h0) begin
      if (gap_cnt_q == `RX_GAP_CYCLES) begin
        bit_cnt_q <= 4'h0;
        gap_cnt_q <= 12'h000;
      end else begin
        gap_cnt_q <= gap_cnt_q + 12'h001;
      end
    end
  end

  // A good frame is handed to the FIFO; the push waits while it is full.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      push_q      <= 1'b0;
      push_data_q <= 8'h00;
    end else if (fall && last_bit && frame_ok) begin
      push_q      <= 1'b1;
      push_data_q <= shift_q[8:1];
    end else if (fifo_in_ready) begin
      push_q      <= 1'b0;
    end
  end

  // Frame error is sticky; a new error wins over the clearing status read.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      frm_err_q <= 1'b0;
    end else if (fall && last_bit && !frame_ok) begin
      frm_err_q <= 1'b1;
    end else if (rd_status) begin
      frm_err_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Clock inhibit
  // -----------------------------------------------------------------

  // Once a byte is taken the clock is held low until software reads it.
  always @* begin
    inhibit_d = inhibit_q;
    if (fall && last_bit && frame_ok) begin
      inhibit_d = 1'b1;
    end else if (rd_data) begin
      inhibit_d = 1'b0;
    end
  end

  // Inhibit state register.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      inhibit_q <= 1'b0;
    end else begin
      inhibit_q <= inhibit_d;
    end
  end

  // -----------------------------------------------------------------
  // Receive FIFO
  // -----------------------------------------------------------------

  // Received bytes queue here; its head is the receive register.
  ps2_rx_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .i_clk       (I_CLOCK),
    .i_reset_n   (I_RESET_N),
    .i_in_valid  (push_q),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_data_q),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (rd_data),
    .o_out_data  (fifo_out_data),
    .o_full      (fifo_full)
  );

  // -----------------------------------------------------------------
  // Interrupt
  // -----------------------------------------------------------------

  // A rising byte-ready sets the pending interrupt; setting beats the
  // clearing read of the source register.
  always @* begin
    int_pend_d = int_pend_q;
    if (fifo_out_valid && !ready_prev_q) begin
      int_pend_d = 1'b1;
    end else if (rd_intsrc) begin
      int_pend_d = 1'b0;
    end
  end

  // The pin takes the next pending value, so it rises one clock after
  // byte-ready and drops in the clock after the clearing read.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      ready_prev_q <= 1'b0;
      int_pend_q   <= 1'b0;
      O_INT        <= 1'b0;
    end else begin
      ready_prev_q <= fifo_out_valid;
      int_pend_q   <= int_pend_d;
      O_INT        <= int_pend_d;
    end
  end

  // -----------------------------------------------------------------
  // Line drivers
  // -----------------------------------------------------------------

  // Pin values come from the next control and inhibit values so that a
  // write or a read shows at the pins one clock later.
  always @* begin
    clk_out_d  = 1'b1;
    clk_oe_n_d = 1'b1;
    dat_out_d  = 1'b1;
    dat_oe_n_d = 1'b1;
    if (!ctrl_d[`RX_CTRL_ENABLE]) begin
      clk_out_d  = ctrl_d[`RX_CTRL_CLK_OVR];
      clk_oe_n_d = 1'b0;
      dat_out_d  = ctrl_d[`RX_CTRL_DAT_OVR];
      dat_oe_n_d = 1'b0;
    end else if (ctrl_d[`RX_CTRL_DIR] || inhibit_d) begin
      clk_out_d  = 1'b0;
      clk_oe_n_d = 1'b0;
    end else begin
      clk_oe_n_d = 1'b1;
      dat_oe_n_d = 1'b1;
    end
  end

  // Registered pin drivers.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      O_LINK_CLK       <= 1'b1;
      O_LINK_CLK_OE_N  <= 1'b1;
      O_LINK_DATA      <= 1'b1;
      O_LINK_DATA_OE_N <= 1'b1;
    end else begin
      O_LINK_CLK       <= clk_out_d;
      O_LINK_CLK_OE_N  <= clk_oe_n_d;
      O_LINK_DATA      <= dat_out_d;
      O_LINK_DATA_OE_N <= dat_oe_n_d;
    end
  end

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------

  // Read mux; unmapped addresses and idle cycles return zero.
  always @* begin
    rdata_d = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        `RX_ADDR_CTRL: begin
          rdata_d = {4'h0, ctrl_q};
        end
        `RX_ADDR_STATUS: begin
          rdata_d = {4'h0, fifo_full, inhibit_q, frm_err_q, fifo_out_valid};
        end
        `RX_ADDR_DATA: begin
          rdata_d = fifo_out_valid ? fifo_out_data : 8'h00;
        end
        `RX_ADDR_INTSRC: begin
          rdata_d = {7'h00, int_pend_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// [design/ps2_rx_fifo.v]
// Small synchronous FIFO with valid and ready on both sides.
`default_nettype none

module ps2_rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_clk,
  input  wire             i_reset_n,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire             o_full
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_ptr_q;
  reg [AW:0]      rd_ptr_q;
  wire            empty;
  wire            full;
  wire            push;
  wire            pop;

  // Pointers carry one extra bit so full and empty are told apart.
  assign empty       = (wr_ptr_q == rd_ptr_q);
  assign full        = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                       (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_q[rd_ptr_q[AW-1:0]];
  assign o_full      = full;

  // Storage is written at the write index.
  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers advance on accepted transfers.
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [design/ps2_rx_regs.vh]
// Register map, field positions, reset values and timing counts of the PS/2 receive channel.
//
// Function
// - Enabled receive mode floats clock and data lines within one clock; the code holds the clock low while a received byte is unread.
// - Each serial bit is sampled from data on a falling link clock edge.
// - Byte-ready flag rises within 1.6 us of the eleventh falling edge.
// - Reading the receive register drops byte-ready within 100 ns.
// - Reading the receive register releases the clock line within 100 ns.
// - Channel disabled drives both lines from the override bits within 100 ns.
// - Byte-ready raises an interrupt, pending until the source register is read.
`ifndef PS2_RX_REGS_VH
`define PS2_RX_REGS_VH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define RX_ADDR_CTRL     4'h0
`define RX_ADDR_STATUS   4'h1
`define RX_ADDR_DATA     4'h2
`define RX_ADDR_INTSRC   4'h3

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define RX_CTRL_ENABLE   0
`define RX_CTRL_DIR      1
`define RX_CTRL_CLK_OVR  2
`define RX_CTRL_DAT_OVR  3
`define RX_STAT_READY    0
`define RX_STAT_FRM_ERR  1
`define RX_STAT_INHIBIT  2
`define RX_STAT_FULL     3
`define RX_INT_PENDING   0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RX_CTRL_RESET    4'hd

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define RX_CLK_PERIOD_NS 100
`define RX_MAX_CLK_US    302
`define RX_GAP_CYCLES    ((`RX_MAX_CLK_US * 1000) / `RX_CLK_PERIOD_NS)
`define RX_FRAME_BITS    4'ha

`endif
